/* File: core/pwcfg_bank.v */
// warning threshold and hiccup/sync configuration registers, with
// the overheat and low-supply warning flags they arm.
// assumes a byte-wide register port from the serial slave on mclk_i,
// and comparator/enable inputs arriving asynchronously from analog.
//
// Functional notes
// - enabled threshold crossed sets matching overheat or low-supply flag
// - overheat code 00 off, 01 105C, 10 115C, 11 125C
// - low-supply code 0..14 selects 4.2 V plus 0.5 V per step
// - low-supply code 1111 disables warning; flag never sets
// - overheat field resets to 00, warning off
// - sync bit 0 makes pin a clock input, 1 a clock output
// - retry-disable bit 1 turns off hiccup and short-circuit protection
// - retry-disable reset value from one factory setting for all four
// - sync direction reset value from factory setting, nominal 0
// - low-supply field resets to 0000, 4.2 V
// - any unmasked warning pulls active-low interrupt low
// - flags sticky; cleared by writing 1 or all channel enables low
`timescale 1ns/10ps
`include "pwcfg_defs.vh"

module pwcfg_bank #(
    parameter        NUM_CH          = 4,
    parameter [0:0]  FUSE_RETRY_DIS  = 1'b0,
    parameter [0:0]  FUSE_SYNC_OUT   = 1'b0
) (
    // clock and reset
    input  wire                mclk_i,
    input  wire                rst_n_i,
    // register port
    input  wire                reg_wr_i,
    input  wire                reg_rd_i,
    input  wire [7:0]          reg_addr_i,
    input  wire [7:0]          reg_wdata_i,
    output reg  [7:0]          reg_rdata_o,
    // analog comparator hits, one per threshold code (asynchronous)
    input  wire [2:0]          overheat_hit_i,
    input  wire [14:0]         low_supply_hit_i,
    input  wire [NUM_CH-1:0]   channel_enable_inputs_i,
    // interrupt mask for the two warnings, 1 = masked
    input  wire [1:0]          warn_mask_i,
    // sync pin
    input  wire                sync_pin_i,
    input  wire                sync_clk_src_i,
    output wire                sync_pin_o,
    output wire                sync_pin_oe_n_o,
    output wire                sync_clk_in_o,
    // protection controls and configuration
    output wire [NUM_CH-1:0]   retry_protect_en_o,
    output wire [NUM_CH-1:0]   short_protect_en_o,
    output wire [1:0]          overheat_limit_sel_o,
    output wire [3:0]          low_supply_limit_sel_o,
    // warning flags and interrupt
    output reg                 overheat_flag_o,
    output reg                 low_supply_flag_o,
    output wire                irq_n_o
);

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    reg  [7:0]          thresh_cfg;
    reg                 sync_out;
    reg  [2:0]          hic_rsvd;
    reg  [NUM_CH-1:0]   retry_dis;

    // -----------------------------------------------------------------
    // input synchronisers: two flops, only the second is read
    // -----------------------------------------------------------------
    reg  [2:0]          ovh_s1, ovh_s2;
    reg  [14:0]         lowv_s1, lowv_s2;
    reg  [NUM_CH-1:0]   en_s1, en_s2;
    reg                 syn_s1, syn_s2;

    always @(posedge mclk_i) begin
        ovh_s1  <= overheat_hit_i;
        ovh_s2  <= ovh_s1;
        lowv_s1 <= low_supply_hit_i;
        lowv_s2 <= lowv_s1;
        en_s1   <= channel_enable_inputs_i;
        en_s2   <= en_s1;
        syn_s1  <= sync_pin_i;
        syn_s2  <= syn_s1;
    end

    // -----------------------------------------------------------------
    // threshold decode
    // -----------------------------------------------------------------
    // the comparators resolve each code; logic only picks the one armed
    function ovh_sel;
        input [1:0] code;
        input [2:0] hit;
        begin
            case (code)
                `PWCFG_OVH_105: ovh_sel = hit[0];
                `PWCFG_OVH_115: ovh_sel = hit[1];
                `PWCFG_OVH_125: ovh_sel = hit[2];
                default:        ovh_sel = 1'b0;
            endcase
        end
    endfunction

    function lowv_sel;
        input [3:0]  code;
        input [14:0] hit;
        begin
            if (code == `PWCFG_LOWV_OFF)
                lowv_sel = 1'b0;
            else
                lowv_sel = hit[code];
        end
    endfunction

    wire [1:0] ovh_code  = thresh_cfg[`PWCFG_OVH_HI:`PWCFG_OVH_LO];
    wire [3:0] lowv_code = thresh_cfg[`PWCFG_LOWV_HI:`PWCFG_LOWV_LO];
    wire       ovh_evt   = ovh_sel(ovh_code, ovh_s2);
    wire       lowv_evt  = lowv_sel(lowv_code, lowv_s2);
    wire       all_off   = ~|en_s2;

    // -----------------------------------------------------------------
    // register writes
    // -----------------------------------------------------------------
    wire wr_th  = reg_wr_i && (reg_addr_i == `PWCFG_ADDR_THRESH);
    wire wr_hic = reg_wr_i && (reg_addr_i == `PWCFG_ADDR_HICCUP);
    wire wr_st  = reg_wr_i && (reg_addr_i == `PWCFG_ADDR_STATUS);

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            thresh_cfg <= `PWCFG_THRESH_RST;
            sync_out   <= FUSE_SYNC_OUT;
            hic_rsvd   <= `PWCFG_RSVD_RST;
            retry_dis  <= {NUM_CH{FUSE_RETRY_DIS}};
        end else begin
            if (wr_th)
                thresh_cfg <= reg_wdata_i;
            if (wr_hic) begin
                sync_out  <= reg_wdata_i[`PWCFG_SYNC_BIT];
                hic_rsvd  <= reg_wdata_i[6:4];
                retry_dis <= reg_wdata_i[`PWCFG_RETRY_HI:`PWCFG_RETRY_LO];
            end
        end
    end

    // -----------------------------------------------------------------
    // sticky warning flags
    // -----------------------------------------------------------------
    // set wins over a same-cycle write-1 clear so no event is lost
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            overheat_flag_o   <= 1'b0;
            low_supply_flag_o <= 1'b0;
        end else begin
            if (ovh_evt)
                overheat_flag_o <= 1'b1;
            else if (all_off || (wr_st && reg_wdata_i[`PWCFG_ST_OVH_BIT]))
                overheat_flag_o <= 1'b0;
            if (lowv_evt)
                low_supply_flag_o <= 1'b1;
            else if (all_off || (wr_st && reg_wdata_i[`PWCFG_ST_LOWV_BIT]))
                low_supply_flag_o <= 1'b0;
        end
    end

    assign irq_n_o = ~((overheat_flag_o & ~warn_mask_i[1]) |
                       (low_supply_flag_o & ~warn_mask_i[0]));

    // -----------------------------------------------------------------
    // read back
    // -----------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!rst_n_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i) begin
            case (reg_addr_i)
                `PWCFG_ADDR_THRESH: reg_rdata_o <= thresh_cfg;
                `PWCFG_ADDR_HICCUP: reg_rdata_o <= {sync_out, hic_rsvd, retry_dis};
                `PWCFG_ADDR_STATUS: reg_rdata_o <= {2'h0, overheat_flag_o,
                                                    low_supply_flag_o, 4'h0};
                default:            reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    // reserved bits feed nothing below, only the read path
    assign sync_pin_o             = sync_clk_src_i & sync_out;
    assign sync_pin_oe_n_o        = ~sync_out;
    assign sync_clk_in_o          = syn_s2 & ~sync_out;
    assign retry_protect_en_o     = ~retry_dis;
    assign short_protect_en_o     = ~retry_dis;
    assign overheat_limit_sel_o   = ovh_code;
    assign low_supply_limit_sel_o = lowv_code;

endmodule

/* File: core/pwcfg_defs.vh */
// constants for the warning threshold and hiccup/sync configuration bank
// included by core/pwcfg_bank.v; definitions only
`ifndef PWCFG_DEFS_VH
`define PWCFG_DEFS_VH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define PWCFG_ADDR_THRESH   8'h09
`define PWCFG_ADDR_HICCUP   8'h0A
`define PWCFG_ADDR_STATUS   8'h0E

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define PWCFG_OVH_HI        5
`define PWCFG_OVH_LO        4
`define PWCFG_LOWV_HI       3
`define PWCFG_LOWV_LO       0
`define PWCFG_SYNC_BIT      7
`define PWCFG_RETRY_HI      3
`define PWCFG_RETRY_LO      0
`define PWCFG_ST_OVH_BIT    5
`define PWCFG_ST_LOWV_BIT   4

// -----------------------------------------------------------------
// codes and reset values
// -----------------------------------------------------------------
`define PWCFG_OVH_OFF       2'h0
`define PWCFG_OVH_105       2'h1
`define PWCFG_OVH_115       2'h2
`define PWCFG_OVH_125       2'h3
`define PWCFG_LOWV_OFF      4'hF
`define PWCFG_THRESH_RST    8'h00
`define PWCFG_RSVD_RST      3'h0

`endif

/* File: dv/pwcfg_analog_model.sv */
// comparator model: temperature and supply to per-code hit vectors
// assumes levels change only on bench clock edges
`timescale 1ns/10ps
module pwcfg_analog_model (
    input  int          temp_c,
    input  int          vin_dv,
    output logic [2:0]  oh_o,
    output logic [14:0] ls_o
);
    // bit n trips above 105+10n degrees
    always_comb
        for (int n = 0; n < 3; n++)
            oh_o[n] = temp_c > 105 + 10 * n;
    // bit n trips below 4.2 V + 0.5 V * n, in tenths
    always_comb
        for (int n = 0; n < 15; n++)
            ls_o[n] = vin_dv < 42 + 5 * n;
endmodule

/* File: dv/pwcfg_bank_asserts.sv */
// checker for the configuration bank ports
// bound to every pwcfg_bank instance, one clock domain
`timescale 1ns/10ps
module pwcfg_bank_asserts #(parameter NUM_CH = 4) (
    input wire mclk_i, rst_n_i, reg_wr_i, sync_clk_src_i,
    input wire [7:0] reg_addr_i, reg_wdata_i,
    input wire [2:0] overheat_hit_i,
    input wire [NUM_CH-1:0] channel_enable_inputs_i,
    input wire [1:0] warn_mask_i, overheat_limit_sel_o,
    input wire [3:0] low_supply_limit_sel_o,
    input wire [NUM_CH-1:0] retry_protect_en_o, short_protect_en_o,
    input wire sync_pin_o, sync_pin_oe_n_o,
    input wire overheat_flag_o, low_supply_flag_o, irq_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sync_drive_a: assert property (!sync_pin_oe_n_o |-> sync_pin_o == sync_clk_src_i)
        else $error("sync pin not driven by clock");
    sync_quiet_a: assert property (sync_pin_oe_n_o |-> !sync_pin_o)
        else $error("sync pin driven in input mode");
    short_follow_a: assert property (retry_protect_en_o == short_protect_en_o)
        else $error("short protect differs from retry");
    irq_level_a: assert property (irq_n_o == !((overheat_flag_o && !warn_mask_i[1]) ||
        (low_supply_flag_o && !warn_mask_i[0])))
        else $error("interrupt level wrong");
    lowv_off_a: assert property (low_supply_limit_sel_o == 4'hF &&
        $past(low_supply_limit_sel_o) == 4'hF |-> !$rose(low_supply_flag_o))
        else $error("low supply flag set while off");
    ovh_cause_a: assert property ($rose(overheat_flag_o) |->
        $past(overheat_hit_i != 3'h0, 2) || $past(overheat_hit_i != 3'h0, 3))
        else $error("overheat flag without hit");
    flag_sticky_a: assert property ($fell(overheat_flag_o) |->
        $past(reg_wr_i && reg_addr_i == 8'h0E && reg_wdata_i[5]) ||
        $past(channel_enable_inputs_i == 0, 2) ||
        $past(channel_enable_inputs_i == 0, 3))
        else $error("overheat flag cleared without cause");
    reset_val_a: assert property ($rose(rst_n_i) |->
        overheat_limit_sel_o == 2'h0 && low_supply_limit_sel_o == 4'h0)
        else $error("threshold fields not reset");
endmodule
bind pwcfg_bank pwcfg_bank_asserts #(.NUM_CH(NUM_CH)) chk_inst (.*);

/* File: dv/test_pwcfg_bank.sv */
// self-checking bench for the configuration bank
// assumes fuse parameters left at their zero defaults
`timescale 1ns/10ps
module test_pwcfg_bank;
    logic mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, d, h;
    logic [2:0] overheat_hit_i;
    logic [14:0] low_supply_hit_i;
    logic [3:0] channel_enable_inputs_i = 4'hF, retry_protect_en_o, short_protect_en_o;
    logic [1:0] warn_mask_i = 0, overheat_limit_sel_o;
    logic [3:0] low_supply_limit_sel_o;
    logic sync_pin_i = 0, sync_clk_src_i = 0, sync_pin_o, sync_pin_oe_n_o, sync_clk_in_o;
    logic overheat_flag_o, low_supply_flag_o, irq_n_o, e;
    int temp_c = 25, vin_dv = 120, seed = 62, n_mismatch = 0, comparisons = 0;
    always #5 mclk_i = ~mclk_i;
    pwcfg_analog_model pwcfg_analog_model_inst (.temp_c(temp_c), .vin_dv(vin_dv),
        .oh_o(overheat_hit_i), .ls_o(low_supply_hit_i));
    pwcfg_bank pwcfg_bank_inst (.*);
    task chk(input string nm, input logic [7:0] x, input logic [7:0] s);
        comparisons++;
        if (x !== s) begin
            n_mismatch++;
            $display("unexpected %0s exp %h got %h", nm, x, s);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
        @(posedge mclk_i) reg_wr_i <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge mclk_i) reg_rd_i <= 0;
        #1 chk("rdata", x, reg_rdata_o);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) {sync_clk_src_i, sync_pin_i} <= $random(seed);
    initial begin
        wt(3);
        rst_n_i <= 1;
        rd(8'h09, 8'h00);
        rd(8'h0A, 8'h00);
        rd(8'h33, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            h = $random(seed);
            wr(8'h09, d);
            wr(8'h0A, h);
            rd(8'h09, d);
            rd(8'h0A, h);
            chk("ovh sel", d[5:4], overheat_limit_sel_o);
            chk("lowv sel", d[3:0], low_supply_limit_sel_o);
            chk("retry", {4'h0, ~h[3:0]}, retry_protect_en_o);
            chk("short", {4'h0, ~h[3:0]}, short_protect_en_o);
            chk("oe_n", {7'h0, ~h[7]}, sync_pin_oe_n_o);
            if (h[7]) chk("clk in", 8'h00, sync_clk_in_o);
        end
        $display("random register test done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h09, {2'h0, c[1:0], 4'hF});
            temp_c = 120;
            wt(4);
            e = (c == 1 || c == 2);
            chk("ovh flag", e, overheat_flag_o);
            chk("irq_n", !e, irq_n_o);
            temp_c = 25;
            wt(4);
            chk("ovh sticky", e, overheat_flag_o);
            rd(8'h0E, {2'h0, e, 5'h00});
            wr(8'h0E, 8'h20);
            wt(1);
            chk("ovh clear", 0, overheat_flag_o);
        end
        $display("overheat test done");
        for (int c = 0; c < 16; c++) begin
            wr(8'h09, c[7:0]);
            warn_mask_i <= {1'b0, c[0]};
            vin_dv = 41 + 5 * c;
            wt(4);
            e = (c != 15);
            chk("lowv flag", e, low_supply_flag_o);
            chk("irq_n", !(e && !c[0]), irq_n_o);
            channel_enable_inputs_i <= 4'h0;
            vin_dv = 120;
            wt(4);
            chk("lowv clear", 0, low_supply_flag_o);
            channel_enable_inputs_i <= 4'hF;
        end
        $display("low supply test done");
        give_verdict();
    end
endmodule
